// >>> core/aqi_defines.svh
`ifndef AQI_DEFINES_SVH
`define AQI_DEFINES_SVH
// Word indices on address pins A4..A1
`define AQI_IDX_ENABLE 4'h9
`define AQI_IDX_STATUS 4'ha
`define AQI_IDX_LIMIT 4'hd
// Reset values
`define AQI_ENABLE_RST 16'h0000
`define AQI_FLAGS_RST 8'h00
// Field positions in enable and status words
`define AQI_TRIG_LSB 8
`define AQI_TRIG_MSB 10
`define AQI_FILL_LSB 11
`define AQI_FILL_MSB 15
// Source bit positions
`define AQI_SRC_WDOG 0
`define AQI_SRC_MATCH 1
`define AQI_SRC_FILL 2
`define AQI_SRC_AZERO 3
`define AQI_SRC_FULLCAL 4
`define AQI_SRC_PAUSE 5
`define AQI_SRC_LOWSUP 6
`define AQI_SRC_WAKE 7
// Timing
`define AQI_CLK_PERIOD_NS 4
`define AQI_SETTLE_NS 10000000
`define AQI_SETTLE_CYC (`AQI_SETTLE_NS / `AQI_CLK_PERIOD_NS)
`endif

// >>> core/aqi_pkg.sv
package aqi_pkg;
    // Bus word and source vector
    typedef logic [15:0] aqi_word_t;
    typedef logic [7:0] aqi_src_t;
    // Watchdog compare phase
    typedef enum logic [0:0] {
        AQI_WD_FIRST = 1'b0,
        AQI_WD_SECOND = 1'b1
    } aqi_wd_state_e;
endpackage : aqi_pkg

// >>> core/aqi_limit_cmp.sv
`timescale 1ns/1ps
`include "aqi_defines.svh"
module aqi_limit_cmp
    import aqi_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic [8:0] sample_in,
    input wire logic [8:0] limit1_in,
    input wire logic [8:0] limit2_in,
    input wire logic above1_in,
    input wire logic above2_in,
    input wire logic [2:0] instr_in,
    input wire logic clear_in,
    input wire logic reset_in,
    output logic hit_out,
    output aqi_word_t status_out
);
    aqi_wd_state_e st; // Compare phase
    logic [8:0] sample_q; // Sample held for second compare
    logic [8:0] lim2_q;
    logic above2_q;
    logic [2:0] instr_q;
    logic hit1;
    logic hit2;
    aqi_word_t set_vec;

    // Signed compare in the selected direction
    function automatic logic crossed(input logic [8:0] s,
                                     input logic [8:0] l,
                                     input logic above);
        crossed = above ? ($signed(s) > $signed(l))
                        : ($signed(s) < $signed(l));
    endfunction : crossed

    // Limit one now, limit two one cycle later
    assign hit1 = (st == AQI_WD_FIRST) && start_in &&
                  crossed(sample_in, limit1_in, above1_in);
    assign hit2 = (st == AQI_WD_SECOND) &&
                  crossed(sample_q, lim2_q, above2_q);
    assign set_vec = (hit1 ? 16'(16'h0001 << instr_in) : 16'h0000) |
                     (hit2 ? 16'(16'h0100 << instr_q) : 16'h0000);

    // Phase sequencing; a soft reset abandons a pending compare
    always_ff @(posedge mclk_in) begin
        if (!nrst_in || reset_in) begin
            st <= AQI_WD_FIRST;
        end else begin
            unique case (st)
                AQI_WD_FIRST: if (start_in) st <= AQI_WD_SECOND;
                AQI_WD_SECOND: st <= AQI_WD_FIRST;
            endcase
        end
    end

    // Operands for the second compare
    always_ff @(posedge mclk_in) begin
        if (st == AQI_WD_FIRST && start_in) begin
            sample_q <= sample_in;
            lim2_q <= limit2_in;
            above2_q <= above2_in;
            instr_q <= instr_in;
        end
    end

    // Which limit and which instruction; set beats read clear
    always_ff @(posedge mclk_in) begin
        if (!nrst_in || reset_in) begin
            status_out <= 16'h0000;
            hit_out <= 1'b0;
        end else begin
            status_out <= (clear_in ? 16'h0000 : status_out) | set_vec;
            hit_out <= hit1 | hit2;
        end
    end

    property p_second_cmp;
        @(posedge mclk_in) disable iff (!nrst_in)
        (hit2 && !reset_in) |=>
            (status_out & 16'(16'h0100 << $past(instr_q))) != 16'h0000;
    endproperty
    a_second_cmp: assert property (p_second_cmp)
        else $error("limit two crossing not recorded");
endmodule : aqi_limit_cmp

// >>> core/aqi_settle_timer.sv
`timescale 1ns/1ps
`include "aqi_defines.svh"
module aqi_settle_timer
    import aqi_pkg::*;
#(
    parameter int unsigned CYCLES = `AQI_SETTLE_CYC
)(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic standby_in,
    output logic done_out
);
    logic standby_q; // Previous standby level
    logic [31:0] cnt; // Cycles left; zero when idle

    // Count from standby release; re-entering standby aborts the wait
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            standby_q <= 1'b0;
            cnt <= 32'h0000_0000;
            done_out <= 1'b0;
        end else begin
            standby_q <= standby_in;
            done_out <= (cnt == 32'h0000_0001) && !standby_in;
            if (standby_in) begin
                cnt <= 32'h0000_0000;
            end else if (standby_q) begin
                cnt <= 32'(CYCLES);
            end else if (cnt != 32'h0000_0000) begin
                cnt <= cnt - 32'h0000_0001;
            end
        end
    end
endmodule : aqi_settle_timer

// >>> core/aqi_interrupt_logic.sv
`timescale 1ns/1ps
`include "aqi_defines.svh"
module aqi_interrupt_logic
    import aqi_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = `AQI_SETTLE_CYC
)(
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Host parallel bus pins
    input wire logic bus_cs_n_in,
    input wire logic bus_rd_n_in,
    input wire logic bus_wr_n_in,
    input wire logic [4:0] bus_addr_in,
    input wire logic [15:0] bus_data_in,
    input wire logic bus_width_select_in,
    output aqi_word_t bus_data_out,
    output logic bus_data_oe_out,
    // Sequencer side
    input wire logic seq_fetch_in,
    input wire logic [2:0] seq_addr_in,
    input wire logic seq_pause_in,
    input wire logic seq_start_in,
    input wire logic seq_reset_in,
    input wire logic seq_running_in,
    output logic seq_halt_out,
    // Watchdog compare request
    input wire logic wd_valid_in,
    input wire logic [8:0] wd_sample_in,
    input wire logic [8:0] wd_limit1_in,
    input wire logic [8:0] wd_limit2_in,
    input wire logic wd_above1_in,
    input wire logic wd_above2_in,
    input wire logic [2:0] wd_instr_in,
    // Other event sources
    input wire logic [5:0] fifo_count_in,
    input wire logic az_done_in,
    input wire logic cal_done_in,
    input wire logic supply_low_in,
    input wire logic standby_in,
    // Toward the host
    output logic int_n_out,
    output logic transfer_request_out
);
    // Pin sampling: cs, rd, wr, width, supply, addr, data
    localparam int PW = 26;
    logic [PW-1:0] pin_meta; // First stage, read only by second
    logic [PW-1:0] pin_sync; // Second stage, safe to use
    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic bw_s;
    logic lowsup_s;
    logic [4:0] addr_s;
    aqi_word_t data_s;

    // Strobe tracking
    logic rd_act; // Read strobe active
    logic rd_act_q;
    logic rd_start; // First cycle of a read
    logic wr_act; // Write strobe active
    logic wr_act_q;
    logic wr_end; // Write taken at strobe release
    logic [4:0] wr_addr_q; // Address held during write
    aqi_word_t wr_data_q; // Data held during write
    logic [3:0] rd_idx;
    logic [3:0] wr_idx;

    // Register state
    aqi_word_t en; // Enable mask, trigger, fill level
    aqi_src_t flags; // Sticky status flags
    aqi_src_t next_flags;
    aqi_src_t ev; // One bit per source this cycle
    logic clr; // Status read clears flags
    aqi_word_t status_word;
    aqi_word_t rd_word;
    aqi_word_t limit_status;

    // Event helpers
    logic [2:0] trig;
    logic [4:0] fill_lvl;
    logic [5:0] count_q; // Count seen last cycle
    logic fill_hit;
    logic start_q;
    logic first_mark; // First fetch of zero still pending
    logic match;
    logic wd_hit;
    logic wake_done;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            // Idle levels: strobes high, supply not low, so no false event
            pin_meta <= {3'b111, 23'h000000};
            pin_sync <= {3'b111, 23'h000000};
        end else begin
            pin_meta <= {bus_cs_n_in, bus_rd_n_in, bus_wr_n_in,
                         bus_width_select_in, supply_low_in,
                         bus_addr_in, bus_data_in};
            pin_sync <= pin_meta;
        end
    end

    // Synchronised pin fields
    assign cs_s = pin_sync[25];
    assign rd_s = pin_sync[24];
    assign wr_s = pin_sync[23];
    assign bw_s = pin_sync[22];
    assign lowsup_s = pin_sync[21];
    assign addr_s = pin_sync[20:16];
    assign data_s = pin_sync[15:0];

    // Read acts at its leading edge, write at its trailing edge
    assign rd_act = !cs_s && !rd_s;
    assign wr_act = !cs_s && !wr_s;
    assign rd_start = rd_act && !rd_act_q;
    assign wr_end = wr_act_q && !wr_act;
    // Same word index in both bus widths; A0 picks a byte
    assign rd_idx = addr_s[4:1];
    assign wr_idx = wr_addr_q[4:1];

    // Strobe history
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end

    // Hold write address and data while the strobe is low, since
    // the pins may already move in the cycle the strobe rises
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            wr_addr_q <= 5'h00;
            wr_data_q <= 16'h0000;
        end else if (wr_act) begin
            wr_addr_q <= addr_s;
            wr_data_q <= data_s;
        end
    end

    // Enable register, word or byte writes
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            en <= `AQI_ENABLE_RST;
        end else if (wr_end && wr_idx == `AQI_IDX_ENABLE) begin
            if (!bw_s) begin
                en <= wr_data_q;
            end else if (!wr_addr_q[0]) begin
                en[7:0] <= wr_data_q[7:0];
            end else begin
                en[15:8] <= wr_data_q[7:0];
            end
        end
    end

    // Trigger fields from the enable word
    assign trig = en[`AQI_TRIG_MSB:`AQI_TRIG_LSB];
    assign fill_lvl = en[`AQI_FILL_MSB:`AQI_FILL_LSB];

    // Start edge and fill history
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            start_q <= 1'b0;
            count_q <= 6'h00;
        end else begin
            start_q <= seq_start_in;
            count_q <= fifo_count_in;
        end
    end

    // Marker set at reset or start, cleared by fetching zero;
    // a start in the same cycle as a fetch keeps it armed
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            first_mark <= 1'b1;
        end else if (seq_reset_in || (seq_start_in && !start_q)) begin
            first_mark <= 1'b1;
        end else if (seq_fetch_in && seq_addr_in == 3'h0) begin
            first_mark <= 1'b0;
        end
    end

    // Match is flagged at fetch, before the instruction runs
    assign match = seq_fetch_in && seq_addr_in == trig &&
                   !(seq_addr_in == 3'h0 && first_mark);

    // Fill level reached on the change into it; zero never fires
    assign fill_hit = fifo_count_in == {1'b0, fill_lvl} &&
                      fill_lvl != 5'h00 &&
                      fifo_count_in != count_q;

    // Watchdog comparisons and limit status
    aqi_limit_cmp u_limit (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .start_in(wd_valid_in),
        .sample_in(wd_sample_in),
        .limit1_in(wd_limit1_in),
        .limit2_in(wd_limit2_in),
        .above1_in(wd_above1_in),
        .above2_in(wd_above2_in),
        .instr_in(wd_instr_in),
        .clear_in(rd_start && rd_idx == `AQI_IDX_LIMIT &&
                  (!bw_s || addr_s[0])),
        .reset_in(seq_reset_in),
        .hit_out(wd_hit),
        .status_out(limit_status)
    );

    // Settling wait after standby release
    aqi_settle_timer #(
        .CYCLES(SETTLE_CYCLES)
    ) u_settle (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .standby_in(standby_in),
        .done_out(wake_done)
    );

    // Gather all eight sources; priority plays no part
    always_comb begin
        ev = 8'h00;
        ev[`AQI_SRC_WDOG] = wd_hit;
        ev[`AQI_SRC_MATCH] = match;
        ev[`AQI_SRC_FILL] = fill_hit;
        ev[`AQI_SRC_AZERO] = az_done_in;
        ev[`AQI_SRC_FULLCAL] = cal_done_in;
        ev[`AQI_SRC_PAUSE] = seq_fetch_in && seq_pause_in;
        // Level: re-asserts while the supply stays low
        ev[`AQI_SRC_LOWSUP] = lowsup_s;
        ev[`AQI_SRC_WAKE] = wake_done;
    end

    // Flags clear on a status read of the low byte (or the word)
    assign clr = rd_start && rd_idx == `AQI_IDX_STATUS &&
                 (!bw_s || !addr_s[0]);

    // Flags ignore enables; an event beats a same-cycle read clear
    always_comb begin
        if (seq_reset_in) begin
            next_flags = `AQI_FLAGS_RST;
        end else begin
            next_flags = ((clr ? 8'h00 : flags) | ev);
        end
    end

    // Sticky flag register
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            flags <= `AQI_FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    // Pin low while any enabled flag stands
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            int_n_out <= 1'b1;
        end else begin
            int_n_out <= ~|(next_flags & en[7:0]);
        end
    end

    // Transfer request rises with the fill flag, falls when empty;
    // the next request needs the flag to be read clear first
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            transfer_request_out <= 1'b0;
        end else if (seq_reset_in || fifo_count_in == 6'h00) begin
            transfer_request_out <= 1'b0;
        end else if (fill_hit && en[`AQI_SRC_FILL] &&
                     !flags[`AQI_SRC_FILL]) begin
            transfer_request_out <= 1'b1;
        end
    end

    // Halt only for a pause; a match never asks for a stop
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            seq_halt_out <= 1'b0;
        end else begin
            seq_halt_out <= seq_fetch_in && seq_pause_in;
        end
    end

    // Live sequencer view in the upper status bits
    always_comb begin
        status_word = {8'h00, flags};
        if (seq_running_in) begin
            status_word[`AQI_TRIG_MSB:`AQI_TRIG_LSB] = seq_addr_in;
            status_word[`AQI_FILL_MSB:`AQI_FILL_LSB] =
                fifo_count_in[4:0];
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        unique case (rd_idx)
            `AQI_IDX_ENABLE: rd_word = en;
            `AQI_IDX_STATUS: rd_word = status_word;
            `AQI_IDX_LIMIT: rd_word = limit_status;
            default: rd_word = 16'h0000;
        endcase
    end

    // Data captured at read start, so the clear cannot hide it
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            bus_data_out <= 16'h0000;
            bus_data_oe_out <= 1'b0;
        end else begin
            bus_data_oe_out <= rd_act;
            if (rd_start) begin
                if (bw_s && addr_s[0]) begin
                    bus_data_out <= {8'h00, rd_word[15:8]};
                end else begin
                    bus_data_out <= rd_word;
                end
            end
        end
    end

    property p_int_level;
        @(posedge mclk_in) disable iff (!nrst_in)
        $stable(en) |-> int_n_out == !(|(flags & en[7:0]));
    endproperty
    a_int_level: assert property (p_int_level)
        else $error("interrupt pin disagrees with enabled flags");

    property p_flag_sticky;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ev != 8'h00 && !seq_reset_in) |=> (flags & $past(ev)) == $past(ev);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("event did not set its flag");

    property p_read_clear;
        @(posedge mclk_in) disable iff (!nrst_in)
        (clr && ev == 8'h00) |=> flags == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read left flags set");

    property p_soft_reset;
        @(posedge mclk_in) disable iff (!nrst_in)
        seq_reset_in |=> flags == 8'h00 && !transfer_request_out;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("device reset left flags set");

    property p_first_skip;
        @(posedge mclk_in) disable iff (!nrst_in)
        (seq_fetch_in && seq_addr_in == 3'h0 && first_mark &&
         !flags[`AQI_SRC_MATCH]) |=> !flags[`AQI_SRC_MATCH];
    endproperty
    a_first_skip: assert property (p_first_skip)
        else $error("first fetch of zero raised match");

    property p_match;
        @(posedge mclk_in) disable iff (!nrst_in)
        (seq_fetch_in && seq_addr_in == trig && !seq_reset_in &&
         !(seq_addr_in == 3'h0 && first_mark))
        |=> flags[`AQI_SRC_MATCH];
    endproperty
    a_match: assert property (p_match)
        else $error("address match not flagged");

    property p_no_stall;
        @(posedge mclk_in) disable iff (!nrst_in)
        seq_halt_out |-> $past(seq_fetch_in && seq_pause_in);
    endproperty
    a_no_stall: assert property (p_no_stall)
        else $error("halt without a pause instruction");

    property p_dma_with_int;
        @(posedge mclk_in) disable iff (!nrst_in)
        $rose(transfer_request_out) |-> !int_n_out;
    endproperty
    a_dma_with_int: assert property (p_dma_with_int)
        else $error("transfer request without interrupt pin");

    property p_pause_flag;
        @(posedge mclk_in) disable iff (!nrst_in)
        (seq_fetch_in && seq_pause_in && !seq_reset_in)
        |=> flags[`AQI_SRC_PAUSE] && seq_halt_out;
    endproperty
    a_pause_flag: assert property (p_pause_flag)
        else $error("pause not flagged with halt");
endmodule : aqi_interrupt_logic

// >>> tb/aqi_host_model.sv
`timescale 1ns/1ps
module aqi_host_model
    import aqi_pkg::*;
(
    input wire logic mclk_in,
    input wire aqi_word_t rdata_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [4:0] addr_out,
    output aqi_word_t wdata_out
);
    // Idle bus: strobes high, nothing selected
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = 5'h00;
        wdata_out = 16'h0000;
    end
    // One 16-bit word access; strobes stay low 4 cycles because the pins
    // pass a 2-flop sync, and addr/data outlive the strobe so a late
    // capture never sees them change
    task automatic access(input logic wr, input logic [3:0] idx,
        input aqi_word_t wd, output aqi_word_t rd);
        @(posedge mclk_in);
        cs_n_out <= 1'b0;
        rd_n_out <= wr;
        wr_n_out <= !wr;
        addr_out <= {idx, 1'b0};
        wdata_out <= wd;
        repeat (4) @(posedge mclk_in);
        rd = rdata_in;
        cs_n_out <= 1'b1;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
        // Released data lines: show the inverse, not a stale copy
        wdata_out <= ~wd;
    endtask : access
endmodule : aqi_host_model

// >>> tb/aqi_interrupt_logic_test.sv
`timescale 1ns/1ps
module aqi_interrupt_logic_test
    import aqi_pkg::*;
;
    logic mclk_in = 1'b0, nrst_in = 1'b0;
    logic cs_n, rd_n, wr_n, ack_oe, halt, int_n, dreq;
    logic [4:0] addr;
    aqi_word_t wdata, rdata, en = 16'h0000, r;
    logic fetch = 1'b0, pause = 1'b0, start = 1'b0, sreset = 1'b0;
    logic running = 1'b0, wdv = 1'b0, ab1 = 1'b0, ab2 = 1'b0;
    logic az = 1'b0, cal = 1'b0, lowsup = 1'b0, stby = 1'b0, bw = 1'b0;
    logic [2:0] saddr = 3'h0, winst = 3'h0;
    logic [8:0] smp = 9'h000, lim1 = 9'h000, lim2 = 9'h000;
    logic [5:0] fcount = 6'h00;
    logic [7:0] exp_flags = 8'h00; // Behavioural model of status flags
    int num_errors = 0, n_checks = 0;

    // 250 MHz device clock
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    aqi_host_model aqi_host_model_i (.mclk_in(mclk_in), .rdata_in(rdata),
        .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .addr_out(addr), .wdata_out(wdata));

    // Settle count shortened so the standby exit fits the run
    aqi_interrupt_logic #(.SETTLE_CYCLES(20)) aqi_interrupt_logic_i (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .bus_cs_n_in(cs_n),
        .bus_rd_n_in(rd_n), .bus_wr_n_in(wr_n), .bus_addr_in(addr),
        .bus_data_in(wdata), .bus_width_select_in(bw),
        .bus_data_out(rdata), .bus_data_oe_out(ack_oe),
        .seq_fetch_in(fetch), .seq_addr_in(saddr), .seq_pause_in(pause),
        .seq_start_in(start), .seq_reset_in(sreset),
        .seq_running_in(running), .seq_halt_out(halt), .wd_valid_in(wdv),
        .wd_sample_in(smp), .wd_limit1_in(lim1), .wd_limit2_in(lim2),
        .wd_above1_in(ab1), .wd_above2_in(ab2), .wd_instr_in(winst),
        .fifo_count_in(fcount), .az_done_in(az), .cal_done_in(cal),
        .supply_low_in(lowsup), .standby_in(stby), .int_n_out(int_n),
        .transfer_request_out(dreq));

    task automatic chk(input aqi_word_t got, input aqi_word_t exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Status reads clear the model flags as they clear the device's
    task automatic rd(input logic [3:0] idx, input aqi_word_t exp);
        fork
            aqi_interrupt_logic_test.aqi_host_model_i.access(1'b0, idx,
                16'h0000, r);
            // Data drive enable stands while the strobe is seen low
            begin
                repeat (5) @(posedge mclk_in);
                #1 chk({15'h0000, ack_oe}, 16'h0001);
            end
        join
        chk(r, exp);
        chk({15'h0000, ack_oe}, 16'h0000);
        if (idx == 4'ha) exp_flags = 8'h00;
    endtask : rd

    // Enable write, always followed by a clearing status read
    task automatic wr_en(input aqi_word_t d);
        aqi_interrupt_logic_test.aqi_host_model_i.access(1'b1, 4'h9, d, r);
        en = d;
        rd(4'ha, 16'h0000);
    endtask : wr_en

    // Pin expected from model flags and enables
    task automatic chk_int();
        #1 chk({15'h0000, int_n}, {15'h0000, ~|(exp_flags & en[7:0])});
    endtask : chk_int

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : tick

    task automatic stop_test();
        $display("errors=%0d checks=%0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // Hang guard
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(37));
        tick(6);
        nrst_in <= 1'b1;
        tick(2);
        rd(4'h9, 16'h0000);
        rd(4'ha, 16'h0000);
        // Calibration and supply events, random enables
        wr_en({8'h00, 8'($urandom())});
        az <= 1'b1;
        tick(1);
        az <= 1'b0;
        cal <= 1'b1;
        tick(1);
        cal <= 1'b0;
        lowsup <= 1'b1;
        tick(2);
        lowsup <= 1'b0;
        tick(5);
        exp_flags = 8'h58;
        chk_int();
        rd(4'ha, 16'h0058);
        chk_int();
        // Watchdog: first limit hit above, then second limit hit below
        winst <= 3'($urandom());
        smp <= 9'h050;
        lim1 <= 9'h010;
        ab1 <= 1'b1;
        lim2 <= 9'h100;
        wdv <= 1'b1;
        tick(1);
        wdv <= 1'b0;
        tick(4);
        rd(4'hd, 16'h0001 << winst);
        rd(4'ha, 16'h0001);
        smp <= 9'h1f0;
        lim2 <= 9'h000;
        wdv <= 1'b1;
        tick(1);
        wdv <= 1'b0;
        tick(4);
        rd(4'hd, 16'h0100 << winst);
        rd(4'ha, 16'h0001);
        // Pause instruction halts and flags source 5
        saddr <= 3'h5;
        fetch <= 1'b1;
        pause <= 1'b1;
        tick(1);
        fetch <= 1'b0;
        pause <= 1'b0;
        #1 chk({15'h0000, halt}, 16'h0001);
        tick(3);
        rd(4'ha, 16'h0020);
        // Match on instruction 0: first fetch after start skipped
        wr_en(16'h0002);
        sreset <= 1'b1;
        tick(1);
        sreset <= 1'b0;
        start <= 1'b1;
        saddr <= 3'h0;
        // Start edge lands one cycle before the first fetch
        tick(1);
        for (int k = 0; k < 3; k++) begin
            fetch <= 1'b1;
            tick(1);
            fetch <= 1'b0;
            #1 chk({15'h0000, halt}, 16'h0000);
            tick(3);
            exp_flags = (k == 0) ? 8'h00 : 8'h02;
            chk_int();
            rd(4'ha, {14'h0000, (k != 0), 1'b0});
        end
        // Every non-zero trigger value
        for (int k = 1; k < 8; k++) begin
            wr_en({5'h00, 3'(k), 8'h02});
            saddr <= 3'(k);
            fetch <= 1'b1;
            tick(1);
            fetch <= 1'b0;
            tick(3);
            rd(4'ha, 16'h0002);
        end
        // Fill level with running sequencer
        wr_en({5'd5, 3'h0, 8'h04});
        running <= 1'b1;
        saddr <= 3'h3;
        fcount <= 6'd4;
        tick(2);
        fcount <= 6'd5;
        tick(1);
        exp_flags = 8'h04;
        chk_int();
        chk({15'h0000, dreq}, 16'h0001);
        rd(4'ha, {5'd5, 3'h3, 8'h04});
        fcount <= 6'd0;
        tick(2);
        #1 chk({15'h0000, dreq}, 16'h0000);
        running <= 1'b0;
        // Soft reset clears flags
        az <= 1'b1;
        tick(1);
        az <= 1'b0;
        tick(2);
        sreset <= 1'b1;
        tick(1);
        sreset <= 1'b0;
        tick(2);
        rd(4'ha, 16'h0000);
        // Standby exit after settling
        wr_en(16'h0080);
        stby <= 1'b1;
        tick(2);
        stby <= 1'b0;
        tick(19);
        chk_int();
        tick(3);
        exp_flags = 8'h80;
        chk_int();
        rd(4'ha, 16'h0080);
        // 8-bit bus: low byte write leaves the trigger byte alone
        bw <= 1'b1;
        tick(3);
        aqi_interrupt_logic_test.aqi_host_model_i.access(1'b1, 4'h9,
            16'hff01, r);
        en = 16'h0001;
        rd(4'ha, 16'h0000);
        rd(4'h9, 16'h0001);
        rd(4'h3, 16'h0000);
        stop_test();
    end
endmodule : aqi_interrupt_logic_test
